/* File: verilog/spc_consts.vh */
// constants for the spindle plc control block
`ifndef SPC_CONSTS_VH
`define SPC_CONSTS_VH
`define SPC_NSPINDLE      2
`define SPC_SPEED_W       16
`define SPC_MCODE_W       8
// register byte offsets
`define SPC_OFF_CTRL      8'h00
`define SPC_OFF_SPEED_CMD 8'h04
`define SPC_OFF_SPEED0    8'h08
`define SPC_OFF_SPEED1    8'h0c
`define SPC_OFF_COIL      8'h10
`define SPC_OFF_MCODE     8'h14
`define SPC_OFF_STATUS    8'h18
// control register fields
`define SPC_CTRL_SRC_BIT  0
`define SPC_CTRL_MSC2_BIT 1
`define SPC_CTRL_RESET    32'h00000000
// coil register fields
`define SPC_COIL_INT_LSB  0
`define SPC_COIL_STS_LSB  4
// mcode register fields
`define SPC_MC_WAIT_BIT   8
`define SPC_MC_PART_BIT   9
// status register fields
`define SPC_ST_POLY_BIT   0
`define SPC_ST_WAIT0_BIT  1
`define SPC_ST_WAIT1_BIT  2
// coil one-hot codes
`define SPC_COIL_L        3'h1
`define SPC_COIL_M        3'h2
`define SPC_COIL_H        3'h4
`endif

/* File: verilog/spc_coil.v */
// coil winding changeover sequencer
`timescale 1ns/1ps
`default_nettype none
module spc_coil
(
  input  wire       clk,
  input  wire       arst_n,
  input  wire       ce,
  input  wire [2:0] request,
  input  wire       speed_detect_flag,
  input  wire       speed_detect_second,
  output reg  [2:0] coil,
  output reg        pending
);
  `include "spc_consts.vh"
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;
  reg [1:0] state;
  reg [2:0] target;
  wire is_up;
  wire flag_ok;
  wire valid_req;
  // any move toward a higher coil is immediate
  assign is_up = (request == `SPC_COIL_H && coil != `SPC_COIL_H) ||
                 (request == `SPC_COIL_M && coil == `SPC_COIL_L);
  // medium needs the second detect, low needs the main detect
  assign flag_ok = (request == `SPC_COIL_M) ? speed_detect_second : speed_detect_flag;
  assign valid_req = (request == `SPC_COIL_L) || (request == `SPC_COIL_M) || (request == `SPC_COIL_H);
  // state and coil update; a new request supersedes a pending one
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state   <= ST_IDLE;
      coil    <= `SPC_COIL_L;
      target  <= `SPC_COIL_L;
      pending <= 1'b0;
    end
    else if (ce)
    begin
      case (state)
        ST_IDLE:
        begin
          if (valid_req && request != coil)
          begin
            if (is_up)
              coil <= request;
            else if (flag_ok)
              coil <= request;
            else
            begin
              state   <= ST_WAIT;
              target  <= request;
              pending <= 1'b1;
            end
          end
        end
        ST_WAIT:
        begin
          if (!valid_req || request == coil)
          begin
            state   <= ST_IDLE;
            pending <= 1'b0;
          end
          else if (request != target && is_up)
          begin
            coil    <= request;
            state   <= ST_IDLE;
            pending <= 1'b0;
          end
          else if (flag_ok)
          begin
            coil    <= request;
            state   <= ST_IDLE;
            pending <= 1'b0;
          end
          else
            target <= request; // coil stays put while waiting
        end
        default:
        begin
          state   <= ST_IDLE;
          pending <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: verilog/spc_top.v */
// spindle plc control signals block with ahb-lite register slave
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module spc_top
(
  input  wire        CLK,
  input  wire        ARST_N,
  input  wire        CE,
  // ahb-lite slave
  input  wire        HSEL,
  input  wire [7:0]  HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  // plc inputs
  input  wire [1:0]  SPINDLE_SELECT,
  input  wire        COIL_CHANGE_OVERRIDE,
  input  wire        LOW_COIL_SELECT,
  input  wire        MEDIUM_COIL_SELECT,
  input  wire        SPEED_DETECT_FLAG,
  input  wire        SPEED_DETECT_SECOND,
  input  wire        WAIT_IGNORE,
  input  wire        POLYGON_CANCEL,
  input  wire        POLYGON_START,
  input  wire        TAP_POLARITY_REVERSE,
  input  wire        TAP_ACTIVE,
  input  wire        TAP_DIR_CMD,
  // outputs
  output reg  [15:0] SPEED0,
  output reg  [15:0] SPEED1,
  output reg  [2:0]  COIL,
  output reg  [7:0]  MCODE_VALUE,
  output reg         MCODE_STROBE,
  output reg  [1:0]  PART_STALL,
  output reg         POLYGON_ACTIVE,
  output reg         SPINDLE_DIR
);
  `include "spc_consts.vh"
  reg  [31:0] ctrl;
  reg  [2:0]  coil_int;
  reg  [15:0] speed [0:1];
  reg  [1:0]  wait_flag;
  reg  [7:0]  wait_code [0:1];
  reg         dp_write;
  reg         dp_read;
  reg  [7:0]  dp_addr;
  reg         mc_go;
  reg  [9:0]  mc_word;
  reg  [15:0] spd_word;
  reg         spd_go;
  reg  [2:0]  coil_req;
  wire [2:0]  coil_now;
  wire        coil_pend;
  wire [2:0]  plc_coil;
  wire        src_internal;
  wire        addr_ok;
  wire        mc_part;
  wire        mc_other;
  wire [31:0] rd_mux;
  integer     i;

  // plc coil request from low/medium selects, neither means high
  assign plc_coil = LOW_COIL_SELECT ? `SPC_COIL_L :
                    (MEDIUM_COIL_SELECT ? `SPC_COIL_M : `SPC_COIL_H);
  assign src_internal = ctrl[`SPC_CTRL_SRC_BIT];
  assign addr_ok = HSEL && HREADY && HTRANS[1];

  // coil source select, registered so the sequencer sees a stable request
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      coil_req <= `SPC_COIL_L;
    else if (CE)
    begin
      if (src_internal && !COIL_CHANGE_OVERRIDE)
        coil_req <= coil_int;
      else
        coil_req <= plc_coil; // override drops internal choice
    end
  end

  spc_coil u_coil
  (
    .clk                 (CLK),
    .arst_n              (ARST_N),
    .ce                  (CE),
    .request             (coil_req),
    .speed_detect_flag   (SPEED_DETECT_FLAG),
    .speed_detect_second (SPEED_DETECT_SECOND),
    .coil                (coil_now),
    .pending             (coil_pend)
  );

  // ahb address phase capture; slave is zero wait state
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      dp_write  <= 1'b0;
      dp_read   <= 1'b0;
      dp_addr   <= 8'h00;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
    else if (CE)
    begin
      dp_write <= addr_ok && HWRITE;
      dp_read  <= addr_ok && !HWRITE;
      if (addr_ok)
        dp_addr <= HADDR;
    end
  end

  // read mux; unmapped addresses read zero
  assign rd_mux =
    (dp_addr == `SPC_OFF_CTRL)   ? ctrl :
    (dp_addr == `SPC_OFF_SPEED0) ? {16'h0000, speed[0]} :
    (dp_addr == `SPC_OFF_SPEED1) ? {16'h0000, speed[1]} :
    (dp_addr == `SPC_OFF_COIL)   ? {24'h000000, coil_pend, coil_now, 1'b0, coil_int} :
    (dp_addr == `SPC_OFF_STATUS) ? {29'h00000000, wait_flag, POLYGON_ACTIVE} :
    32'h00000000;

  // hrdata registered in the address phase so it stands in the data phase
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      HRDATA <= 32'h00000000;
    else if (CE)
    begin
      if (addr_ok && !HWRITE)
      begin
        case (HADDR)
          `SPC_OFF_CTRL:   HRDATA <= ctrl;
          `SPC_OFF_SPEED0: HRDATA <= {16'h0000, speed[0]};
          `SPC_OFF_SPEED1: HRDATA <= {16'h0000, speed[1]};
          `SPC_OFF_COIL:   HRDATA <= {24'h000000, coil_pend, coil_now, 1'b0, coil_int};
          `SPC_OFF_STATUS: HRDATA <= {29'h00000000, wait_flag, POLYGON_ACTIVE};
          default:         HRDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // register writes in the data phase; speed and mcode writes are commands
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ctrl     <= `SPC_CTRL_RESET;
      coil_int <= `SPC_COIL_L;
      spd_go   <= 1'b0;
      spd_word <= 16'h0000;
      mc_go    <= 1'b0;
      mc_word  <= 10'h000;
    end
    else if (CE)
    begin
      spd_go <= 1'b0;
      mc_go  <= 1'b0;
      if (dp_write)
      begin
        case (dp_addr)
          `SPC_OFF_CTRL:      ctrl <= {30'h00000000, HWDATA[1:0]};
          `SPC_OFF_COIL:      coil_int <= HWDATA[2:0];
          `SPC_OFF_SPEED_CMD:
          begin
            spd_word <= HWDATA[15:0];
            spd_go   <= 1'b1;
          end
          `SPC_OFF_MCODE:
          begin
            mc_word <= HWDATA[9:0];
            mc_go   <= 1'b1;
          end
          default:            ctrl <= ctrl; // unmapped write ignored
        endcase
      end
    end
  end

  // per-spindle speed latch; in mode two deselected spindles keep their speed
  generate
    genvar g;
    for (g = 0; g < 2; g = g + 1)
    begin : g_spd
      always @(posedge CLK or negedge ARST_N)
      begin
        if (!ARST_N)
          speed[g] <= 16'h0000;
        else if (CE && spd_go)
        begin
          // without mode two every spindle follows the command
          if (!ctrl[`SPC_CTRL_MSC2_BIT] || SPINDLE_SELECT[g])
            speed[g] <= spd_word;
        end
      end
    end
  endgenerate

  assign mc_part  = mc_word[`SPC_MC_PART_BIT];
  assign mc_other = ~mc_word[`SPC_MC_PART_BIT];

  // m code handling and part system waiting
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      wait_flag    <= 2'b00;
      wait_code[0] <= 8'h00;
      wait_code[1] <= 8'h00;
      MCODE_VALUE  <= 8'h00;
      MCODE_STROBE <= 1'b0;
    end
    else if (CE)
    begin
      MCODE_STROBE <= 1'b0;
      if (WAIT_IGNORE)
        wait_flag <= 2'b00; // all waits dropped
      else if (mc_go && mc_word[`SPC_MC_WAIT_BIT])
      begin
        // the matching code from the other part releases both
        if (wait_flag[mc_other] && wait_code[mc_other] == mc_word[7:0])
          wait_flag <= 2'b00;
        else
        begin
          wait_flag[mc_part] <= 1'b1;
          wait_code[mc_part] <= mc_word[7:0];
        end
      end
      // only ordinary codes reach the plc outputs
      if (mc_go && !mc_word[`SPC_MC_WAIT_BIT])
      begin
        MCODE_VALUE  <= mc_word[7:0];
        MCODE_STROBE <= 1'b1;
      end
    end
  end

  // output flops; polygon cancel beats start
  always @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      SPEED0         <= 16'h0000;
      SPEED1         <= 16'h0000;
      COIL           <= `SPC_COIL_L;
      PART_STALL     <= 2'b00;
      POLYGON_ACTIVE <= 1'b0;
      SPINDLE_DIR    <= 1'b0;
    end
    else if (CE)
    begin
      SPEED0 <= speed[0];
      SPEED1 <= speed[1];
      COIL   <= coil_now;
      PART_STALL <= WAIT_IGNORE ? 2'b00 : wait_flag;
      // cancel wins even while idle, so a held start cannot re-enter the mode
      if (POLYGON_CANCEL)
        POLYGON_ACTIVE <= 1'b0;
      else if (POLYGON_START)
        POLYGON_ACTIVE <= 1'b1;
      // reversal only applies while tapping
      SPINDLE_DIR <= TAP_DIR_CMD ^ (TAP_ACTIVE & TAP_POLARITY_REVERSE);
    end
  end
endmodule
`default_nettype wire

/* File: test/spc_plc.sv */
// plc sequence model driving the coil selection lines
`timescale 1ns/1ps
`default_nettype none
module spc_plc
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic want_low,
  input  wire logic want_med,
  input  wire logic want_ovr,
  output var  logic low_sel,
  output var  logic med_sel,
  output var  logic override
);
  // override waits a cycle behind the selects, so no half-made choice is seen
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      low_sel <= 1'h0;
      med_sel <= 1'h0;
      override <= 1'h0;
    end
    else
    begin
      low_sel <= want_low;
      med_sel <= want_med;
      override <= want_ovr && low_sel == want_low && med_sel == want_med;
    end
endmodule
`default_nettype wire

/* File: test/spc_chk.sv */
// assertion checker for the spindle plc control block
`timescale 1ns/1ps
`default_nettype none
module spc_chk
(
  input wire logic        CLK, ARST_N, HSEL, HWRITE, HREADY, MCODE_STROBE, POLYGON_ACTIVE, POLYGON_CANCEL,
  input wire logic        SPINDLE_DIR, TAP_DIR_CMD, TAP_ACTIVE, TAP_POLARITY_REVERSE, SPEED_DETECT_FLAG,
  input wire logic        SPEED_DETECT_SECOND, WAIT_IGNORE,
  input wire logic [7:0]  HADDR,
  input wire logic [1:0]  HTRANS, PART_STALL,
  input wire logic [31:0] HWDATA,
  input wire logic [15:0] SPEED0, SPEED1,
  input wire logic [2:0]  COIL
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  logic       aw;
  logic       mw;
  logic [4:0] sq;
  logic [3:0] oq;
  // history of speed writes and ordinary code writes, wide enough for the output lag
  assign aw = HSEL && HREADY && HTRANS[1] && HWRITE;
  always_ff @(posedge CLK or negedge ARST_N)
    if (!ARST_N)
    begin
      mw <= 1'h0;
      sq <= 5'h00;
      oq <= 4'h0;
    end
    else
    begin
      mw <= aw && HADDR == 8'h14;
      sq <= {sq[3:0], aw && HADDR == 8'h04};
      oq <= {oq[2:0], mw && !HWDATA[8]};
    end
  sequence s_sd_seen;
    $past(SPEED_DETECT_FLAG) || $past(SPEED_DETECT_FLAG, 2) || $past(SPEED_DETECT_FLAG, 3);
  endsequence
  sequence s_sd2_seen;
    $past(SPEED_DETECT_SECOND) || $past(SPEED_DETECT_SECOND, 2) || $past(SPEED_DETECT_SECOND, 3);
  endsequence
  a_low_needs_flag: assert property (COIL == 3'h1 && $past(COIL) != 3'h1 |-> s_sd_seen)
    else $error("coil fell to low without speed detect");
  a_med_needs_sd2: assert property (COIL == 3'h2 && $past(COIL) == 3'h4 |-> s_sd2_seen)
    else $error("coil fell to medium without second detect");
  a_tap_dir: assert property ($past(ARST_N) |-> SPINDLE_DIR ==
    ($past(TAP_DIR_CMD) ^ ($past(TAP_ACTIVE) & $past(TAP_POLARITY_REVERSE))))
    else $error("spindle direction wrong");
  a_strobe_cause: assert property (MCODE_STROBE |-> |oq)
    else $error("strobe without ordinary code");
  a_ignore_stall: assert property (WAIT_IGNORE [*3] |-> PART_STALL == 2'h0)
    else $error("stall while waits ignored");
  a_poly_cancel: assert property (POLYGON_CANCEL |-> ##[1:2] !POLYGON_ACTIVE)
    else $error("polygon not cancelled");
  a_speed0_hold: assert property (!$stable(SPEED0) |-> |sq)
    else $error("speed 0 moved without command");
  a_speed1_hold: assert property (!$stable(SPEED1) |-> |sq)
    else $error("speed 1 moved without command");
endmodule
bind spc_top spc_chk chk (.*);
`default_nettype wire

/* File: test/spc_top_tb.sv */
// self-checking bench for the spindle plc control block
`timescale 1ns/1ps
`default_nettype none
module spc_top_tb;
  logic        CLK = 0, ARST_N = 0, CE = 1, HSEL = 0, HWRITE = 0, wl = 0, wm = 0, wo = 0;
  logic        SPEED_DETECT_FLAG = 0, SPEED_DETECT_SECOND = 0, WAIT_IGNORE = 0, POLYGON_CANCEL = 0;
  logic        POLYGON_START = 0, TAP_POLARITY_REVERSE = 0, TAP_ACTIVE = 0, TAP_DIR_CMD = 0;
  logic [7:0]  HADDR = 8'h00;
  logic [1:0]  HTRANS = 2'h0, SPINDLE_SELECT = 2'h0;
  logic [2:0]  HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h0, q;
  wire logic   HREADY, HREADYOUT, HRESP, LOW_COIL_SELECT, MEDIUM_COIL_SELECT, COIL_CHANGE_OVERRIDE;
  wire logic   MCODE_STROBE, POLYGON_ACTIVE, SPINDLE_DIR;
  wire logic [31:0] HRDATA;
  wire logic [15:0] SPEED0, SPEED1;
  wire logic [2:0]  COIL;
  wire logic [7:0]  MCODE_VALUE;
  wire logic [1:0]  PART_STALL;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_strobe = 0;
  assign HREADY = HREADYOUT;
  spc_top dut (.*);
  spc_plc plc (.clk(CLK), .arst_n(ARST_N), .want_low(wl), .want_med(wm), .want_ovr(wo),
    .low_sel(LOW_COIL_SELECT), .med_sel(MEDIUM_COIL_SELECT), .override(COIL_CHANGE_OVERRIDE));
  initial forever #25 CLK = ~CLK;
  // strobes counted at the edge, so a stray one between checks is still caught
  always @(posedge CLK)
    if (MCODE_STROBE === 1'h1)
      n_strobe++;
  task automatic close_out;
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic ok);
    n_tests++;
    if (ok !== 1'h1)
    begin
      n_mismatch++;
      $display("[FAIL] %0t output mismatch", $time);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // single word transfer; each wait ends when ready is high, and a wait on a ready that never comes is ended by the watchdog
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    HSEL <= 1'h1;
    HADDR <= a;
    HTRANS <= 2'h2;
    HWRITE <= w;
    do @(posedge CLK); while (HREADY !== 1'h1);
    HSEL <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADY !== 1'h1);
    q = HRDATA;
  endtask
  task automatic t_speed;
    bus(1'h1, 8'h00, 32'h2);
    @(posedge CLK) SPINDLE_SELECT <= 2'h1;
    bus(1'h1, 8'h04, 32'h1234);
    tick(3);
    chk(SPEED0 === 16'h1234 && SPEED1 === 16'h0000);
    @(posedge CLK) SPINDLE_SELECT <= 2'h2;
    bus(1'h1, 8'h04, 32'h0abc);
    tick(3);
    chk(SPEED0 === 16'h1234 && SPEED1 === 16'h0abc);
    bus(1'h1, 8'h00, 32'h0);
    @(posedge CLK) SPINDLE_SELECT <= 2'h0;
    bus(1'h1, 8'h04, 32'h0055);
    tick(3);
    chk(SPEED0 === 16'h0055 && SPEED1 === 16'h0055);
    bus(1'h0, 8'h1c, 32'h0);
    chk(q === 32'h0 && HRESP === 1'h0);
  endtask
  task automatic t_coil;
    chk(COIL === 3'h4);
    @(posedge CLK) wm <= 1'h1;
    // pending is sampled at the read address phase, so let it settle first
    tick(4);
    bus(1'h0, 8'h10, 32'h0);
    chk(COIL === 3'h4 && q[7] === 1'h1);
    @(posedge CLK) SPEED_DETECT_SECOND <= 1'h1;
    tick(3);
    chk(COIL === 3'h2);
    @(posedge CLK) wl <= 1'h1;
    tick(6);
    chk(COIL === 3'h2);
    @(posedge CLK) SPEED_DETECT_FLAG <= 1'h1;
    tick(3);
    chk(COIL === 3'h1);
    @(posedge CLK) wl <= 1'h0;
    tick(4);
    chk(COIL === 3'h2);
    bus(1'h1, 8'h10, 32'h4);
    bus(1'h1, 8'h00, 32'h1);
    tick(4);
    chk(COIL === 3'h4);
    @(posedge CLK);
    wl <= 1'h1;
    wo <= 1'h1;
    tick(6);
    chk(COIL === 3'h1);
    @(posedge CLK) wo <= 1'h0;
    tick(5);
    chk(COIL === 3'h4);
  endtask
  task automatic t_mcode;
    n_strobe = 0;
    bus(1'h1, 8'h14, 32'h005);
    tick(4);
    chk(n_strobe == 1 && MCODE_VALUE === 8'h05);
    bus(1'h1, 8'h14, 32'h107);
    tick(4);
    chk(n_strobe == 1 && PART_STALL === 2'h1);
    bus(1'h1, 8'h14, 32'h307);
    tick(4);
    chk(n_strobe == 1 && PART_STALL === 2'h0);
    bus(1'h1, 8'h14, 32'h109);
    @(posedge CLK) WAIT_IGNORE <= 1'h1;
    bus(1'h1, 8'h14, 32'h30b);
    tick(4);
    chk(n_strobe == 1 && PART_STALL === 2'h0);
  endtask
  task automatic t_poly;
    @(posedge CLK) POLYGON_START <= 1'h1;
    @(posedge CLK) POLYGON_START <= 1'h0;
    tick(2);
    chk(POLYGON_ACTIVE === 1'h1);
    @(posedge CLK);
    POLYGON_CANCEL <= 1'h1;
    POLYGON_START <= 1'h1;
    tick(2);
    chk(POLYGON_ACTIVE === 1'h0);
  endtask
  task automatic t_tap;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge CLK) {TAP_ACTIVE, TAP_POLARITY_REVERSE, TAP_DIR_CMD} <= i[2:0];
      tick(1);
      chk(SPINDLE_DIR === (i[0] ^ (i[2] & i[1])));
    end
  endtask
  initial
  begin
    repeat (5) @(posedge CLK);
    ARST_N <= 1'h1;
    t_speed;
    t_coil;
    t_mcode;
    t_poly;
    t_tap;
    close_out;
  end
  // the sequence needs some 140 cycles; far beyond that counts as a hang
  initial
  begin
    #200000;
    n_mismatch++;
    close_out;
  end
endmodule
`default_nettype wire
